// ==== rtl/supervisor_control_registers.sv ====
// Control and miscellaneous configuration registers of the voltage supervisor.
// What this block does
// RULE_01 - Two-bit scale field forces comparator gain: none, 1x, 2x or 4x.
// RULE_02 - Sleep power bit picks low (0, reset) or high sleep power.
// RULE_03 - Writing 1 to reset bit triggers full device reset; bit reads 0.
// RULE_04 - Writing 1 to counter-clear bit clears rail-tag pulse counter; reads 0. The code drops a clear written during the full reset pulse.
// RULE_05 - Force-tag bit drives tag pin low; otherwise sequence logic owns it.
// RULE_06 - Force-irq bit drives irq pin low; otherwise enabled faults own it.
// RULE_07 - Timestamp overwrite off and ready set: new sequence keeps stored timestamps.
// RULE_08 - Order overwrite off: new sequence does not replace a ready log.
// RULE_09 - Checking on and required: missing check byte is a fault.
// RULE_10 - Checking on, not required: missing byte accepted; require ignored when off.
// RULE_11 - Check enable bit turns checking off at 0 (reset) and on at 1.
// RULE_12 - Writing 0 to self-clearing bits does nothing; each 1 acts once. A counter-clear 1 written during the full reset pulse does not act.
`timescale 1ns/100ps
`default_nettype none

module supervisor_control_registers (
  input  wire logic                                i_sys_clk,
  input  wire logic                                i_reset,
  input  wire supervisor_ctrl_pkg::reg_access_type i_reg,
  output logic [7:0]                               o_reg_rdata,
  output logic                                     o_reg_rvalid,
  output logic [1:0]                               o_comparator_gain_select,
  output logic                                     o_gain_force_active,
  output logic [2:0]                               o_gain_factor,
  output logic                                     o_sleep_power_level,
  output logic                                     o_full_reset,
  output logic                                     o_tag_counter_clear,
  input  wire logic                                i_seq_tag_assert,
  input  wire logic                                i_tag_pin_in,
  output logic                                     o_tag_pin_out,
  output logic                                     o_tag_pin_oe,
  output logic                                     o_tag_pin_level,
  input  wire logic                                i_fault_irq_assert,
  input  wire logic                                i_irq_pin_n_in,
  output logic                                     o_irq_pin_n_out,
  output logic                                     o_irq_pin_n_oe,
  output logic                                     o_irq_pin_n_level,
  input  wire logic [supervisor_ctrl_pkg::SEQ_KINDS-1:0] i_seq_event,
  input  wire logic [supervisor_ctrl_pkg::SEQ_KINDS-1:0] i_order_log_ready,
  input  wire logic                                i_timestamp_ready,
  output logic [supervisor_ctrl_pkg::SEQ_KINDS-1:0] o_order_log_store,
  output logic                                     o_timestamp_store,
  input  wire supervisor_ctrl_pkg::txn_report_type i_txn,
  output logic                                     o_txn_accept,
  output logic                                     o_check_fault
);

  // Gain factor forced by a scale field code; none when no override.
  function automatic logic [2:0] gain_factor_of(input logic [1:0] code);
    logic [2:0] factor;
    factor = supervisor_ctrl_pkg::GAIN_FACTOR_NONE;
    unique case (code)
      supervisor_ctrl_pkg::GAIN_NO_FORCE: factor = supervisor_ctrl_pkg::GAIN_FACTOR_NONE;
      supervisor_ctrl_pkg::GAIN_FORCE_1X: factor = supervisor_ctrl_pkg::GAIN_FACTOR_1X;
      supervisor_ctrl_pkg::GAIN_FORCE_2X: factor = supervisor_ctrl_pkg::GAIN_FACTOR_2X;
      supervisor_ctrl_pkg::GAIN_FORCE_4X: factor = supervisor_ctrl_pkg::GAIN_FACTOR_4X;
    endcase
    return factor;
  endfunction : gain_factor_of

  supervisor_ctrl_pkg::monitor_control_type     ctl_q;
  supervisor_ctrl_pkg::monitor_control_type     ctl_d;
  supervisor_ctrl_pkg::monitor_misc_config_type misc_q;
  supervisor_ctrl_pkg::monitor_misc_config_type misc_d;
  supervisor_ctrl_pkg::monitor_control_type     ctl_wr;
  logic                                         ctl_hit;
  logic                                         misc_hit;
  logic                                         ctl_write;
  logic                                         misc_write;
  logic                                         reg_clear;
  logic                                         full_reset_d;
  logic                                         full_reset_q;
  logic                                         tag_clear_d;
  logic                                         tag_clear_q;
  logic [7:0]                                   ctl_read;
  logic [7:0]                                   rdata_d;
  logic [7:0]                                   rdata_q;
  logic                                         rvalid_q;
  logic [supervisor_ctrl_pkg::SEQ_KINDS-1:0]    order_store_d;
  logic [supervisor_ctrl_pkg::SEQ_KINDS-1:0]    order_store_q;
  logic                                         ts_store_d;
  logic                                         ts_store_q;

  // Address decode of the register port.
  assign ctl_hit    = (i_reg.addr == supervisor_ctrl_pkg::MONITOR_CONTROL_ADDR);
  assign misc_hit   = (i_reg.addr == supervisor_ctrl_pkg::MONITOR_MISC_CONFIG_ADDR);
  assign ctl_write  = i_reg.wr & ctl_hit;
  assign misc_write = i_reg.wr & misc_hit;
  assign ctl_wr     = supervisor_ctrl_pkg::monitor_control_type'(i_reg.wdata);

  // The self-clearing bits never store; each write of 1 launches one pulse, except a counter clear written during the reset pulse.
  assign full_reset_d = ctl_write & ctl_wr.protected_full_reset; // [RULE_03] [RULE_12]
  assign tag_clear_d  = ctl_write & ctl_wr.tag_counter_clear; // [RULE_04] [RULE_12]

  // Next register values; stored bits follow writes, self-clearing bits stay zero.
  always_comb begin
    ctl_d  = ctl_q;
    misc_d = misc_q;
    if (ctl_write) begin
      ctl_d                      = ctl_wr;
      ctl_d.protected_full_reset = 1'b0; // [RULE_03]
      ctl_d.tag_counter_clear    = 1'b0; // [RULE_04]
    end
    if (misc_write) begin
      misc_d = supervisor_ctrl_pkg::monitor_misc_config_type'(i_reg.wdata);
    end
  end

  // A full device reset returns both registers to their reset values.
  assign reg_clear = i_reset | full_reset_q; // [RULE_03]

  // Register storage.
  always_ff @(posedge i_sys_clk) begin
    if (reg_clear) begin
      ctl_q  <= supervisor_ctrl_pkg::monitor_control_type'(
                  supervisor_ctrl_pkg::MONITOR_CONTROL_RESET);
      misc_q <= supervisor_ctrl_pkg::monitor_misc_config_type'(
                  supervisor_ctrl_pkg::MONITOR_MISC_CONFIG_RESET);
    end else begin
      ctl_q  <= ctl_d;
      misc_q <= misc_d;
    end
  end

  // Action pulses; the reset pulse is not itself cleared by the full reset.
  // A clear launched beside the reset pulse is dropped with the reset.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      full_reset_q <= 1'b0;
      tag_clear_q  <= 1'b0;
    end else begin
      full_reset_q <= full_reset_d;
      tag_clear_q  <= tag_clear_d & ~full_reset_q;
    end
  end

  assign o_full_reset        = full_reset_q; // [RULE_03]
  assign o_tag_counter_clear = tag_clear_q; // [RULE_04]

  // Read mux; the self-clearing bits always read back as zero.
  always_comb begin
    ctl_read                                            = ctl_q;
    ctl_read[supervisor_ctrl_pkg::FULL_RESET_POS]      = 1'b0; // [RULE_03]
    ctl_read[supervisor_ctrl_pkg::TAG_CLEAR_POS]       = 1'b0; // [RULE_04]
    if (ctl_hit) begin
      rdata_d = ctl_read;
    end else if (misc_hit) begin
      rdata_d = misc_q;
    end else begin
      rdata_d = supervisor_ctrl_pkg::READ_UNMAPPED_VALUE;
    end
  end

  // Read data is captured on the edge that takes the read request.
  // Unmapped reads still answer, with zero data.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rdata_q  <= supervisor_ctrl_pkg::READ_UNMAPPED_VALUE;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= i_reg.rd;
      if (i_reg.rd) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign o_reg_rdata  = rdata_q;
  assign o_reg_rvalid = rvalid_q;

  // Comparator gain override and sleep power level.
  assign o_comparator_gain_select = ctl_q.comparator_gain_select; // [RULE_01]
  assign o_gain_force_active      =
    (ctl_q.comparator_gain_select != supervisor_ctrl_pkg::GAIN_NO_FORCE); // [RULE_01]
  assign o_gain_factor            = gain_factor_of(ctl_q.comparator_gain_select); // [RULE_01]
  assign o_sleep_power_level      = ctl_q.sleep_power_level; // [RULE_02]

  // Open-drain pins only ever pull low; release hands the pin to its owner.
  assign o_tag_pin_out     = 1'b0;
  assign o_tag_pin_oe      = ctl_q.force_tag_pin_low | i_seq_tag_assert; // [RULE_05]
  assign o_tag_pin_level   = i_tag_pin_in;
  assign o_irq_pin_n_out   = 1'b0;
  assign o_irq_pin_n_oe    = ctl_q.force_irq_pin_low | i_fault_irq_assert; // [RULE_06]
  assign o_irq_pin_n_level = i_irq_pin_n_in;

  // Log write permission per sequence kind; unread logs are kept unless overwrite is allowed.
  genvar kind;
  generate
    for (kind = 0; kind < supervisor_ctrl_pkg::SEQ_KINDS; kind++) begin : g_order_gate
      assign order_store_d[kind] = i_seq_event[kind] &
                                   (misc_q.order_log_overwrite_allow |
                                    ~i_order_log_ready[kind]); // [RULE_08]
    end
  endgenerate

  assign ts_store_d = (|i_seq_event) &
                      (misc_q.timestamp_overwrite_allow | ~i_timestamp_ready); // [RULE_07]

  // Store strobes go out one edge after the sequence event.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      order_store_q <= '0;
      ts_store_q    <= 1'b0;
    end else begin
      order_store_q <= order_store_d;
      ts_store_q    <= ts_store_d;
    end
  end

  assign o_order_log_store = order_store_q;
  assign o_timestamp_store = ts_store_q;

  // Packet check byte policy.
  check_byte_policy u_check_byte_policy (
    .i_sys_clk             (i_sys_clk),
    .i_reset               (i_reset),
    .i_txn                 (i_txn),
    .i_check_byte_enable   (misc_q.check_byte_enable), // [RULE_11]
    .i_check_byte_required (misc_q.check_byte_required),
    .o_txn_accept          (o_txn_accept),
    .o_check_fault         (o_check_fault)
  );

  // Control writes reach the stored fields one edge later.
  chk_gain_factor_map: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_01]
    (ctl_write && !full_reset_q) |=> (o_comparator_gain_select == $past(i_reg.wdata[7:6]) &&
      o_gain_factor == gain_factor_of($past(i_reg.wdata[7:6]))))
    else $error("Gain override did not follow the written scale field.");

  chk_sleep_level_write: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_02]
    (ctl_write && !full_reset_q) |=> (o_sleep_power_level == $past(i_reg.wdata[5])))
    else $error("Sleep power level did not follow the write.");

  chk_gain_force_flag: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_01]
    (ctl_write && !full_reset_q) |=> (o_gain_force_active == ($past(i_reg.wdata[7:6]) != 2'h0)))
    else $error("Gain force flag is wrong.");

  // The full reset pulse restores both registers.
  chk_full_reset_defaults: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_03]
    full_reset_d |=> o_full_reset ##1 (ctl_q == supervisor_ctrl_pkg::MONITOR_CONTROL_RESET &&
      misc_q == supervisor_ctrl_pkg::MONITOR_MISC_CONFIG_RESET))
    else $error("Full reset did not pulse and restore defaults.");

  // Control reads never show the action bits.
  chk_reset_bits_readzero: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_03]
    (i_reg.rd && ctl_hit) |=> (o_reg_rvalid && o_reg_rdata[3:2] == 2'h0))
    else $error("Self-clearing bits read back nonzero.");

  chk_self_clear_store: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_12]
    ctl_write |=> (!ctl_q.protected_full_reset && !ctl_q.tag_counter_clear))
    else $error("A self-clearing bit was stored.");

  chk_tag_clear_once: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_04]
    o_tag_counter_clear |-> ($past(ctl_write) && $past(i_reg.wdata[2])) ##1
      (!o_tag_counter_clear || $past(tag_clear_d)))
    else $error("Tag counter clear pulsed without a matching write.");

  chk_zero_write_inert: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_12]
    (ctl_write && !i_reg.wdata[3] && !i_reg.wdata[2]) |=> (!o_full_reset && !o_tag_counter_clear))
    else $error("Writing zero to a self-clearing bit had an effect.");

  // Forced pins pull low; released pins follow their owner.
  chk_tag_pin_force: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_05]
    (ctl_write && i_reg.wdata[1] && !full_reset_q) |=> (o_tag_pin_oe && !o_tag_pin_out))
    else $error("Force bit did not pull the tag pin low.");

  chk_tag_pin_release: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_05]
    (ctl_write && !i_reg.wdata[1]) ##1 !i_seq_tag_assert |-> !o_tag_pin_oe)
    else $error("Released tag pin still pulled low.");

  chk_irq_pin_force: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_06]
    (ctl_write && i_reg.wdata[0] && !full_reset_q) |=> (o_irq_pin_n_oe && !o_irq_pin_n_out))
    else $error("Force bit did not pull the irq pin low.");

  chk_irq_pin_release: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_06]
    (ctl_write && !i_reg.wdata[0]) ##1 !i_fault_irq_assert |-> !o_irq_pin_n_oe)
    else $error("Released irq pin still pulled low.");

  // Store strobes honour the overwrite permissions.
  chk_timestamp_kept: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_07]
    (!misc_q.timestamp_overwrite_allow && i_timestamp_ready) |=> !o_timestamp_store)
    else $error("Ready timestamps were overwritten.");

  chk_timestamp_allowed: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_07]
    ((|i_seq_event) && misc_q.timestamp_overwrite_allow) |=> o_timestamp_store)
    else $error("Allowed timestamp store missing.");

  chk_order_log_kept: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_08]
    (i_seq_event[0] && i_order_log_ready[0] && !misc_q.order_log_overwrite_allow)
      |=> !o_order_log_store[0])
    else $error("Ready power-on log was overwritten.");

  chk_order_log_allowed: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_08]
    (i_seq_event != '0 && misc_q.order_log_overwrite_allow)
      |=> (o_order_log_store == $past(i_seq_event)))
    else $error("Allowed log overwrite did not store.");

  // The check policy sees the stored enable bit.
  chk_check_enable_write: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_11]
    (misc_write && !full_reset_q) |=> (misc_q.check_byte_enable == $past(i_reg.wdata[0])))
    else $error("Check enable bit did not follow the write.");

endmodule : supervisor_control_registers

`default_nettype wire

// ==== include/supervisor_ctrl_pkg.sv ====
// Constants and types shared by the supervisor control register bank.
package supervisor_ctrl_pkg;

  // Register addresses on the serial register port.
  localparam logic [7:0] MONITOR_CONTROL_ADDR     = 8'h10;
  localparam logic [7:0] MONITOR_MISC_CONFIG_ADDR = 8'h11;

  // Reset values of the two registers.
  localparam logic [7:0] MONITOR_CONTROL_RESET     = 8'h00;
  localparam logic [7:0] MONITOR_MISC_CONFIG_RESET = 8'h0C;
  localparam logic [7:0] READ_UNMAPPED_VALUE       = 8'h00;

  // Field positions in the control register.
  localparam int GAIN_HI_POS      = 7;
  localparam int GAIN_LO_POS      = 6;
  localparam int SLEEP_POS        = 5;
  localparam int CTL_SPARE_POS    = 4;
  localparam int FULL_RESET_POS   = 3;
  localparam int TAG_CLEAR_POS    = 2;
  localparam int FORCE_TAG_POS    = 1;
  localparam int FORCE_IRQ_POS    = 0;

  // Field positions in the miscellaneous configuration register.
  localparam int TS_OW_POS        = 3;
  localparam int ORDER_OW_POS     = 2;
  localparam int CHECK_REQ_POS    = 1;
  localparam int CHECK_EN_POS     = 0;

  // Comparator gain override encodings and the gain factors they force.
  localparam logic [1:0] GAIN_NO_FORCE = 2'h0;
  localparam logic [1:0] GAIN_FORCE_1X = 2'h1;
  localparam logic [1:0] GAIN_FORCE_2X = 2'h2;
  localparam logic [1:0] GAIN_FORCE_4X = 2'h3;
  localparam logic [2:0] GAIN_FACTOR_NONE = 3'h0;
  localparam logic [2:0] GAIN_FACTOR_1X   = 3'h1;
  localparam logic [2:0] GAIN_FACTOR_2X   = 3'h2;
  localparam logic [2:0] GAIN_FACTOR_4X   = 3'h4;

  // Sleep power levels.
  localparam logic SLEEP_LOW_POWER  = 1'b0;
  localparam logic SLEEP_HIGH_POWER = 1'b1;

  // Number of sequence kinds: power on, power off, exit sleep, enter sleep.
  localparam int SEQ_KINDS = 4;

  // Stored contents of the control register.
  typedef struct packed {
    logic [1:0] comparator_gain_select;
    logic       sleep_power_level;
    logic       spare;
    logic       protected_full_reset;
    logic       tag_counter_clear;
    logic       force_tag_pin_low;
    logic       force_irq_pin_low;
  } monitor_control_type;

  // Stored contents of the miscellaneous configuration register.
  typedef struct packed {
    logic [3:0] spare;
    logic       timestamp_overwrite_allow;
    logic       order_log_overwrite_allow;
    logic       check_byte_required;
    logic       check_byte_enable;
  } monitor_misc_config_type;

  // One register port access from the serial interface engine.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_access_type;

  // End-of-transaction report from the serial interface engine.
  typedef struct packed {
    logic done;
    logic check_present;
    logic check_good;
  } txn_report_type;

endpackage : supervisor_ctrl_pkg

// ==== rtl/check_byte_policy.sv ====
// Packet check byte policy applied at the end of each serial transaction.
`timescale 1ns/100ps
`default_nettype none

module check_byte_policy (
  input  wire logic                           i_sys_clk,
  input  wire logic                           i_reset,
  input  wire supervisor_ctrl_pkg::txn_report_type i_txn,
  input  wire logic                           i_check_byte_enable,
  input  wire logic                           i_check_byte_required,
  output logic                                o_txn_accept,
  output logic                                o_check_fault
);

  logic bad_present;
  logic bad_missing;
  logic fault_d;
  logic fault_q;
  logic accept_q;

  // A present byte that mismatches is bad; a missing one is bad only when required.
  assign bad_present = i_txn.check_present & ~i_txn.check_good;
  assign bad_missing = ~i_txn.check_present & i_check_byte_required; // [RULE_09] [RULE_10]
  assign fault_d     = i_txn.done & i_check_byte_enable & (bad_present | bad_missing); // [RULE_11]

  // One-cycle verdict pulses, one edge after the transaction ends.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      fault_q  <= 1'b0;
      accept_q <= 1'b0;
    end else begin
      fault_q  <= fault_d;
      accept_q <= i_txn.done & ~fault_d;
    end
  end

  assign o_check_fault = fault_q;
  assign o_txn_accept  = accept_q;

  chk_required_fault: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_09]
    (i_txn.done && i_check_byte_enable && i_check_byte_required && !i_txn.check_present)
      |=> (o_check_fault && !o_txn_accept))
    else $error("Missing required check byte did not fault.");

  chk_lenient_accept: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_10]
    (i_txn.done && i_check_byte_enable && !i_check_byte_required && !i_txn.check_present)
      |=> (o_txn_accept && !o_check_fault))
    else $error("Missing optional check byte was not accepted.");

  chk_disabled_no_fault: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [RULE_11]
    !i_check_byte_enable |=> !o_check_fault)
    else $error("Check fault raised while checking is off.");

endmodule : check_byte_policy

`default_nettype wire

// ==== test/pin_partner.sv ====
// Open-drain pin model with pull-ups for the tag and interrupt lines.
`timescale 1ns/100ps
`default_nettype none

module pin_partner (
  input  wire logic i_tag_out,
  input  wire logic i_tag_oe,
  input  wire logic i_irq_n_out,
  input  wire logic i_irq_n_oe,
  output logic      o_tag_wire,
  output logic      o_irq_n_wire
);
  // A released line is pulled up, so it reads high and never keeps a stale low.
  assign o_tag_wire   = i_tag_oe ? i_tag_out : 1'b1;
  assign o_irq_n_wire = i_irq_n_oe ? i_irq_n_out : 1'b1;
endmodule : pin_partner

`default_nettype wire

// ==== test/test_supervisor_control_registers.sv ====
// Self-checking testbench of the supervisor control register bank.
`timescale 1ns/100ps
`default_nettype none

module test_supervisor_control_registers;
  logic                                i_sys_clk;
  logic                                i_reset;
  supervisor_ctrl_pkg::reg_access_type reg_in;
  supervisor_ctrl_pkg::txn_report_type txn;
  logic                                seq_tag;
  logic                                fault_irq;
  logic [3:0]                          seq_event;
  logic [3:0]                          log_ready;
  logic                                ts_ready;
  logic [7:0]                          rdata;
  logic                                rvalid;
  logic [1:0]                          gain_sel;
  logic                                gain_force;
  logic [2:0]                          gain_factor;
  logic                                sleep;
  logic                                full_reset;
  logic                                tag_clear;
  logic                                tag_out;
  logic                                tag_oe;
  logic                                tag_level;
  logic                                tag_wire;
  logic                                irq_out;
  logic                                irq_oe;
  logic                                irq_level;
  logic                                irq_wire;
  logic [3:0]                          order_store;
  logic                                ts_store;
  logic                                txn_accept;
  logic                                check_fault;
  int                                  fails = 0;
  int                                  comparisons = 0;
  int                                  cycles = 0;
  logic [2:0]                          factors [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
  logic [7:0]                          misc_case [6] = '{8'h00, 8'h02, 8'h01, 8'h03, 8'h03, 8'h01};
  logic [1:0]                          txn_case [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h2};
  logic                                fault_case [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};

  supervisor_control_registers supervisor_control_registers_inst (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_reg(reg_in), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .o_comparator_gain_select(gain_sel),
    .o_gain_force_active(gain_force), .o_gain_factor(gain_factor),
    .o_sleep_power_level(sleep), .o_full_reset(full_reset), .o_tag_counter_clear(tag_clear),
    .i_seq_tag_assert(seq_tag), .i_tag_pin_in(tag_wire), .o_tag_pin_out(tag_out),
    .o_tag_pin_oe(tag_oe), .o_tag_pin_level(tag_level), .i_fault_irq_assert(fault_irq),
    .i_irq_pin_n_in(irq_wire), .o_irq_pin_n_out(irq_out), .o_irq_pin_n_oe(irq_oe),
    .o_irq_pin_n_level(irq_level), .i_seq_event(seq_event), .i_order_log_ready(log_ready),
    .i_timestamp_ready(ts_ready), .o_order_log_store(order_store),
    .o_timestamp_store(ts_store), .i_txn(txn), .o_txn_accept(txn_accept),
    .o_check_fault(check_fault));

  pin_partner pin_partner_inst (
    .i_tag_out(tag_out), .i_tag_oe(tag_oe), .i_irq_n_out(irq_out), .i_irq_n_oe(irq_oe),
    .o_tag_wire(tag_wire), .o_irq_n_wire(irq_wire));

  // The clock toggles every 12.5 ns, half of its 25 ns period.
  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task test_done;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  // Compares one byte-wide result and counts it.
  task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : check8

  // One write on the register port; returns just after the edge that takes it.
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge i_sys_clk);
    #2 reg_in = {1'b1, 1'b0, addr, data};
    @(posedge i_sys_clk);
    #2 reg_in.wr = 1'b0;
  endtask : write_reg

  // One read on the register port, checked against the expected byte.
  task automatic read_check(input logic [7:0] addr, input logic [7:0] exp);
    @(posedge i_sys_clk);
    #2 reg_in = {1'b0, 1'b1, addr, 8'h00};
    @(posedge i_sys_clk);
    #2 reg_in.rd = 1'b0;
    check8("rvalid", 8'h01, {7'h00, rvalid});
    check8("rdata", exp, rdata);
  endtask : read_check

  // One-cycle sequence event pulse; store strobes are visible on return.
  task automatic pulse_seq(input logic [3:0] ev);
    @(posedge i_sys_clk);
    #2 seq_event = ev;
    @(posedge i_sys_clk);
    #2 seq_event = 4'h0;
  endtask : pulse_seq

  // One-cycle end-of-transaction report; the verdict is visible on return.
  task automatic pulse_txn(input logic [1:0] present_good);
    @(posedge i_sys_clk);
    #2 txn = {1'b1, present_good};
    @(posedge i_sys_clk);
    #2 txn = 3'h0;
  endtask : pulse_txn

  // A hang is cut short after a cycle ceiling well above the test length.
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      test_done();
    end
  end

  // Main sequence of register accesses and event stimulus.
  initial begin
    reg_in = '0;
    txn = '0;
    seq_tag = 1'b0;
    fault_irq = 1'b0;
    seq_event = 4'h0;
    log_ready = 4'h0;
    ts_ready = 1'b0;
    i_reset = 1'b1;
    repeat (5) @(posedge i_sys_clk);
    #2 i_reset = 1'b0;
    read_check(8'h10, 8'h00);
    read_check(8'h11, 8'h0C);
    read_check(8'h20, 8'h00);
    for (int g = 0; g < 4; g++) begin
      write_reg(8'h10, {2'(g), 6'h20});
      check8("gain_factor", {5'h00, factors[g]}, {5'h00, gain_factor});
      check8("gain_force", {7'h00, g != 0}, {7'h00, gain_force});
      check8("gain_sel", {6'h00, 2'(g)}, {6'h00, gain_sel});
      check8("sleep", 8'h01, {7'h00, sleep});
      read_check(8'h10, {2'(g), 6'h20});
    end
    write_reg(8'h10, 8'h04);
    check8("tag_clear", 8'h01, {7'h00, tag_clear});
    @(posedge i_sys_clk);
    #2 check8("tag_clear", 8'h00, {7'h00, tag_clear});
    read_check(8'h10, 8'h00);
    write_reg(8'h10, 8'h00);
    check8("clear_and_reset", 8'h00, {6'h00, tag_clear, full_reset});
    write_reg(8'h10, 8'h03);
    check8("pin_levels", 8'h00, {6'h00, tag_level, irq_level});
    read_check(8'h10, 8'h03);
    write_reg(8'h10, 8'h00);
    check8("pin_levels", 8'h03, {6'h00, tag_level, irq_level});
    seq_tag = 1'b1;
    fault_irq = 1'b1;
    #1 check8("pin_levels", 8'h00, {6'h00, tag_level, irq_level});
    seq_tag = 1'b0;
    fault_irq = 1'b0;
    write_reg(8'h11, 8'h00);
    log_ready = 4'h1;
    ts_ready = 1'b1;
    pulse_seq(4'h1);
    check8("stores", 8'h00, {3'h0, ts_store, order_store});
    log_ready = 4'h5;
    ts_ready = 1'b0;
    pulse_seq(4'hF);
    check8("stores", 8'h1A, {3'h0, ts_store, order_store});
    write_reg(8'h11, 8'h0C);
    log_ready = 4'hF;
    ts_ready = 1'b1;
    pulse_seq(4'hA);
    check8("stores", 8'h1A, {3'h0, ts_store, order_store});
    log_ready = 4'h0;
    for (int k = 0; k < 6; k++) begin
      write_reg(8'h11, misc_case[k]);
      pulse_txn(txn_case[k]);
      check8("txn_verdict", {6'h00, fault_case[k], !fault_case[k]},
             {6'h00, check_fault, txn_accept});
    end
    write_reg(8'h10, 8'h2B);
    check8("full_reset", 8'h01, {7'h00, full_reset});
    @(posedge i_sys_clk);
    #2 check8("full_reset", 8'h00, {7'h00, full_reset});
    check8("pin_levels", 8'h03, {6'h00, tag_level, irq_level});
    read_check(8'h10, 8'h00);
    read_check(8'h11, 8'h0C);
    test_done();
  end
endmodule : test_supervisor_control_registers

`default_nettype wire
